// *** dcc_pkg.sv ***
// Behaviour
// R1: Yield mode adds one idle cycle per store.
// R2: Request start mode ignores the yield bit.
// R3: Highest three-bit priority wins the bus.
// R4: Equal priority: lowest channel number wins.
// R5: Normal mode stops, clears channel-on at end.
// R6: Circular request mode restarts index, stays on.
// R7: Source address fixed or steps by width.
// R8: Destination address fixed or steps by width.
// R9: Immediate start, or wait for peripheral request.
// R10: No interrupt while interrupt-enable bit is low.
// R11: Width code selects one, two, four bytes.
// R12: Channel-on enables; off means fully idle. The code first lets an item already in its load or store run to its end.
// R13: Index equals item count after item: interrupt.
// R14: Length value is items minus one.
// R15: One grant per item, re-arbitrate after each.
package dcc_pkg;
    localparam int ADDR_W = 8;
    localparam int IDX_W = 16;
    localparam int PRIO_W = 3;
    localparam int NUM_EV = 2;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_INDEX = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CLR = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_IEN = 8'h10;
    localparam int B_ON = 0;
    localparam int F_WIDTH = 1;
    localparam int B_IRQEN = 3;
    localparam int B_REQ = 4;
    localparam int B_DINC = 5;
    localparam int B_SINC = 6;
    localparam int B_CIRC = 7;
    localparam int F_PRIO = 8;
    localparam int B_YIELD = 11;
    localparam int B_EDGE = 13;
    localparam int EV_MATCH = 0;
    localparam int EV_DONE = 1;
    localparam logic [15:0] CTRL_MASK = 16'h3fff;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [1:0] WID_BYTE = 2'h0;
    localparam logic [1:0] WID_HALF = 2'h1;
    localparam logic [1:0] WID_WORD = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_WAIT = 5'h02,
        ST_RD = 5'h04,
        ST_WR = 5'h08,
        ST_GAP = 5'h10
    } dcc_state_t;
endpackage

// *** dcc_channel.sv ***
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
module dcc_channel #(
    parameter int NUM_CH = 4,
    parameter int CH_ID = 0
) (
    input wire logic aclk, // System clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic awvalid, // Write address valid.
    output logic awready, // Write address ready.
    input wire logic [dcc_pkg::ADDR_W-1:0] awaddr, // Write byte address.
    input wire logic wvalid, // Write data valid.
    output logic wready, // Write data ready.
    input wire logic [31:0] wdata, // Write data.
    input wire logic [3:0] wstrb, // Write byte strobes.
    output logic bvalid, // Write response valid.
    input wire logic bready, // Write response ready.
    output logic [1:0] bresp, // Write response code.
    input wire logic arvalid, // Read address valid.
    output logic arready, // Read address ready.
    input wire logic [dcc_pkg::ADDR_W-1:0] araddr, // Read byte address.
    output logic rvalid, // Read data valid.
    input wire logic rready, // Read data ready.
    output logic [31:0] rdata, // Read data.
    output logic [1:0] rresp, // Read response code.
    input wire logic [31:0] src_start_i, // Source start address.
    input wire logic [31:0] dst_start_i, // Destination start address.
    input wire logic [dcc_pkg::IDX_W-1:0] transfer_length_i, // Items minus one.
    input wire logic [dcc_pkg::IDX_W-1:0] irq_item_count_i, // Index for count interrupt.
    output logic [dcc_pkg::IDX_W-1:0] item_index_o, // Current item index.
    input wire logic dreq_i, // Selected peripheral request.
    input wire logic [NUM_CH-1:0] peer_req_i, // Bus requests of all channels.
    input wire logic [dcc_pkg::PRIO_W*NUM_CH-1:0] peer_prio_i, // Their priorities.
    output logic bus_request_o, // This channel competes now.
    output logic [dcc_pkg::PRIO_W-1:0] channel_priority_o, // This channel's priority.
    output logic mem_valid_o, // Bus access request.
    output logic mem_write_o, // Access is a store.
    output logic [31:0] mem_addr_o, // Access byte address.
    output logic [1:0] mem_size_o, // Access width code.
    output logic [31:0] mem_wdata_o, // Store data.
    input wire logic mem_ready_i, // Access completes.
    input wire logic [31:0] mem_rdata_i, // Load data.
    output logic irq_o // Interrupt, level, active high.
);
    if (NUM_CH < 1 || CH_ID < 0 || CH_ID >= NUM_CH) begin : g_chk
        $error("dcc_channel: CH_ID must lie in 0 to NUM_CH-1");
    end

    logic awv_q, awv_d, wv_q, wv_d, bv_q, bv_d, rv_q, rv_d;
    logic [dcc_pkg::ADDR_W-1:0] aw_q, aw_d;
    logic [31:0] w_q, w_d, rd_q, rd_d;
    logic [3:0] ws_q, ws_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic do_wr, wr_ctrl, wr_clr, wr_ien;
    logic [15:0] ctrl_wv;
    logic [31:0] rd_val;
    logic rd_err;

    logic [15:0] ctrl_q, ctrl_d;
    dcc_pkg::dcc_state_t state_q, state_d;
    logic [dcc_pkg::IDX_W-1:0] idx_q, idx_d;
    logic [dcc_pkg::NUM_EV-1:0] sts_q, sts_d, ien_q, ien_d, ev;
    logic pend_q, pend_d, dprev_q, mv_q, mv_d, mw_q, mw_d;
    logic [31:0] data_q, data_d, ma_q, ma_d;
    logic [1:0] width_code, shf;
    logic [dcc_pkg::PRIO_W-1:0] prio;
    logic [NUM_CH-1:0] lose_hi, lose_eq;
    logic win, go, last, wr_done, circ_ok, yield;
    logic [31:0] ioff, src_addr, dst_addr;

    assign awready = !awv_q;
    assign wready = !wv_q;
    assign arready = !rv_q;
    assign bvalid = bv_q;
    assign bresp = br_q;
    assign rvalid = rv_q;
    assign rdata = rd_q;
    assign rresp = rr_q;
    assign do_wr = awv_q && wv_q && !bv_q;
    assign wr_ctrl = do_wr && aw_q == dcc_pkg::OFF_CTRL;
    assign wr_clr = do_wr && aw_q == dcc_pkg::OFF_CLR && ws_q[0];
    assign wr_ien = do_wr && aw_q == dcc_pkg::OFF_IEN && ws_q[0];

    always_comb begin
        ctrl_wv = ctrl_q;
        if (ws_q[0]) begin
            ctrl_wv[7:0] = w_q[7:0];
        end
        if (ws_q[1]) begin
            ctrl_wv[15:8] = w_q[15:8];
        end
        ctrl_wv = ctrl_wv & dcc_pkg::CTRL_MASK;
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
        case (araddr)
            dcc_pkg::OFF_CTRL: rd_val = {16'h0000, ctrl_q};
            dcc_pkg::OFF_INDEX: rd_val = {16'h0000, idx_q};
            dcc_pkg::OFF_STAT: rd_val = 32'(sts_q);
            dcc_pkg::OFF_CLR: rd_val = 32'h0000_0000;
            dcc_pkg::OFF_IEN: rd_val = 32'(ien_q);
            default: rd_err = 1'b1;
        endcase
    end

    always_comb begin
        awv_d = awv_q;
        aw_d = aw_q;
        wv_d = wv_q;
        w_d = w_q;
        ws_d = ws_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        if (awvalid && awready) begin
            awv_d = 1'b1;
            aw_d = awaddr;
        end
        if (wvalid && wready) begin
            wv_d = 1'b1;
            w_d = wdata;
            ws_d = wstrb;
        end
        if (bv_q && bready) begin
            bv_d = 1'b0;
        end
        if (do_wr) begin
            awv_d = 1'b0;
            wv_d = 1'b0;
            bv_d = 1'b1;
            br_d = (aw_q == dcc_pkg::OFF_CTRL || aw_q == dcc_pkg::OFF_CLR ||
                    aw_q == dcc_pkg::OFF_IEN) ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
        end
        if (rv_q && rready) begin
            rv_d = 1'b0;
        end
        if (arvalid && arready) begin
            rv_d = 1'b1;
            rd_d = rd_val;
            rr_d = rd_err ? dcc_pkg::RESP_SLVERR : dcc_pkg::RESP_OKAY;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awv_q <= 1'b0;
            aw_q <= '0;
            wv_q <= 1'b0;
            w_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            bv_q <= 1'b0;
            br_q <= dcc_pkg::RESP_OKAY;
            rv_q <= 1'b0;
            rd_q <= 32'h0000_0000;
            rr_q <= dcc_pkg::RESP_OKAY;
        end else begin
            awv_q <= awv_d;
            aw_q <= aw_d;
            wv_q <= wv_d;
            w_q <= w_d;
            ws_q <= ws_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
        end
    end

    // The reserved width code steps like a word so the address never stalls.
    assign width_code = ctrl_q[dcc_pkg::F_WIDTH+:2]; // [R11]
    assign shf = (width_code == 2'h3) ? dcc_pkg::WID_WORD : width_code; // [R11]
    assign ioff = {16'h0000, idx_q} << shf;
    assign src_addr = src_start_i + (ctrl_q[dcc_pkg::B_SINC] ? ioff : 32'h0000_0000); // [R7]
    assign dst_addr = dst_start_i + (ctrl_q[dcc_pkg::B_DINC] ? ioff : 32'h0000_0000); // [R8]
    assign prio = ctrl_q[dcc_pkg::F_PRIO+:dcc_pkg::PRIO_W];

    always_comb begin
        lose_hi = '0;
        lose_eq = '0;
        for (int j = 0; j < NUM_CH; j++) begin
            if (j != CH_ID && peer_req_i[j]) begin
                lose_hi[j] = peer_prio_i[dcc_pkg::PRIO_W*j+:dcc_pkg::PRIO_W] > prio; // [R3]
                lose_eq[j] = peer_prio_i[dcc_pkg::PRIO_W*j+:dcc_pkg::PRIO_W] == prio
                             && j < CH_ID; // [R4]
            end
        end
    end

    assign win = !(|lose_hi) && !(|lose_eq);
    assign go = !ctrl_q[dcc_pkg::B_REQ] ||
                (ctrl_q[dcc_pkg::B_EDGE] ? pend_q : dreq_i); // [R9]
    assign last = idx_q == transfer_length_i; // [R14]
    assign wr_done = state_q == dcc_pkg::ST_WR && mem_ready_i;
    assign circ_ok = ctrl_q[dcc_pkg::B_CIRC] && ctrl_q[dcc_pkg::B_REQ]; // [R6]
    assign yield = ctrl_q[dcc_pkg::B_YIELD] && !ctrl_q[dcc_pkg::B_REQ]; // [R1] [R2]

    always_comb begin
        ctrl_d = ctrl_q;
        state_d = state_q;
        idx_d = idx_q;
        ien_d = ien_q;
        pend_d = pend_q || (dreq_i && !dprev_q);
        data_d = data_q;
        mv_d = mv_q;
        mw_d = mw_q;
        ma_d = ma_q;
        ev = '0;
        case (state_q)
            dcc_pkg::ST_IDLE: begin
                mv_d = 1'b0;
                pend_d = 1'b0;
                if (ctrl_q[dcc_pkg::B_ON]) begin // [R12]
                    idx_d = '0;
                    state_d = dcc_pkg::ST_WAIT;
                end
            end
            dcc_pkg::ST_WAIT: begin
                if (!ctrl_q[dcc_pkg::B_ON]) begin // [R12]
                    state_d = dcc_pkg::ST_IDLE;
                end else if (go && win) begin // [R3] [R4] [R9]
                    state_d = dcc_pkg::ST_RD;
                    mv_d = 1'b1;
                    mw_d = 1'b0;
                    ma_d = src_addr; // [R7]
                    // A fresh request edge in the start cycle is kept for the next item.
                    pend_d = dreq_i && !dprev_q;
                end
            end
            dcc_pkg::ST_RD: begin
                if (mem_ready_i) begin
                    data_d = mem_rdata_i;
                    mw_d = 1'b1;
                    ma_d = dst_addr; // [R8]
                    state_d = dcc_pkg::ST_WR;
                end
            end
            dcc_pkg::ST_WR: begin
                if (mem_ready_i) begin
                    mv_d = 1'b0;
                    mw_d = 1'b0;
                    // Compared before the index moves on.
                    ev[dcc_pkg::EV_MATCH] = idx_q == irq_item_count_i; // [R13]
                    state_d = yield ? dcc_pkg::ST_GAP : dcc_pkg::ST_WAIT; // [R1] [R15]
                    if (last) begin // [R14]
                        idx_d = '0; // [R5] [R6]
                        ev[dcc_pkg::EV_DONE] = 1'b1;
                        if (!circ_ok) begin
                            ctrl_d[dcc_pkg::B_ON] = 1'b0; // [R5]
                            state_d = dcc_pkg::ST_IDLE;
                        end
                    end else begin
                        idx_d = idx_q + 1'b1;
                    end
                end
            end
            dcc_pkg::ST_GAP: state_d = dcc_pkg::ST_WAIT; // [R1]
            default: state_d = dcc_pkg::ST_IDLE;
        endcase
        // A software write of channel-on wins over the end-of-transfer clear.
        if (wr_ctrl) begin
            ctrl_d = ctrl_wv;
        end
        if (wr_ien) begin
            ien_d = w_q[dcc_pkg::NUM_EV-1:0];
        end
        sts_d = wr_clr ? (sts_q & ~w_q[dcc_pkg::NUM_EV-1:0]) : sts_q;
        if (ctrl_q[dcc_pkg::B_IRQEN]) begin // [R10]
            sts_d = sts_d | ev;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= dcc_pkg::CTRL_RST;
            state_q <= dcc_pkg::ST_IDLE;
            idx_q <= '0;
            sts_q <= '0;
            ien_q <= '0;
            pend_q <= 1'b0;
            dprev_q <= 1'b0;
            data_q <= 32'h0000_0000;
            mv_q <= 1'b0;
            mw_q <= 1'b0;
            ma_q <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            state_q <= state_d;
            idx_q <= idx_d;
            sts_q <= sts_d;
            ien_q <= ien_d;
            pend_q <= pend_d;
            dprev_q <= dreq_i;
            data_q <= data_d;
            mv_q <= mv_d;
            mw_q <= mw_d;
            ma_q <= ma_d;
        end
    end

    assign item_index_o = idx_q;
    assign bus_request_o = state_q == dcc_pkg::ST_WAIT && ctrl_q[dcc_pkg::B_ON] && go;
    assign channel_priority_o = prio;
    assign mem_valid_o = mv_q;
    assign mem_write_o = mw_q;
    assign mem_addr_o = ma_q;
    assign mem_size_o = width_code;
    assign mem_wdata_o = data_q;
    assign irq_o = |(sts_q & ien_q);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_gap_wait;
        state_q == dcc_pkg::ST_GAP ##1 state_q == dcc_pkg::ST_WAIT;
    endsequence
    sequence s_store_at(logic [31:0] a);
        mem_valid_o && mem_write_o && mem_addr_o == a;
    endsequence

    property p_yield;
        wr_done && yield && !(last && !circ_ok) |=> s_gap_wait;
    endproperty
    a_yield: assert property (p_yield) else $error("yield gap missing"); // [R1]
    property p_req_no_gap;
        wr_done && ctrl_q[dcc_pkg::B_REQ] |=> state_q != dcc_pkg::ST_GAP;
    endproperty
    a_req_no_gap: assert property (p_req_no_gap) else $error("gap in request mode"); // [R2]
    property p_prio;
        state_q == dcc_pkg::ST_WAIT && (|lose_hi) |=> state_q != dcc_pkg::ST_RD;
    endproperty
    a_prio: assert property (p_prio) else $error("lower priority granted"); // [R3]
    property p_tie;
        state_q == dcc_pkg::ST_WAIT && (|lose_eq) |=> state_q != dcc_pkg::ST_RD;
    endproperty
    a_tie: assert property (p_tie) else $error("tie granted to higher number"); // [R4]
    property p_stop;
        wr_done && last && !circ_ok && !wr_ctrl |=>
            !ctrl_q[dcc_pkg::B_ON] && idx_q == '0 ##1 state_q == dcc_pkg::ST_IDLE;
    endproperty
    a_stop: assert property (p_stop) else $error("normal end did not stop"); // [R5]
    property p_circ;
        wr_done && last && circ_ok && !wr_ctrl |=> ctrl_q[dcc_pkg::B_ON] && idx_q == '0;
    endproperty
    a_circ: assert property (p_circ) else $error("circular restart wrong"); // [R6]
    property p_src;
        state_q == dcc_pkg::ST_WAIT && ctrl_q[dcc_pkg::B_ON] && go && win |=>
            mem_valid_o && !mem_write_o && mem_addr_o == $past(src_addr);
    endproperty
    a_src: assert property (p_src) else $error("bad source address"); // [R7]
    property p_dst;
        state_q == dcc_pkg::ST_RD && mem_ready_i |=> s_store_at($past(dst_addr));
    endproperty
    a_dst: assert property (p_dst) else $error("bad destination address"); // [R8]
    property p_wait_req;
        state_q == dcc_pkg::ST_WAIT && ctrl_q[dcc_pkg::B_REQ] && !go |=>
            state_q != dcc_pkg::ST_RD;
    endproperty
    a_wait_req: assert property (p_wait_req) else $error("started without request"); // [R9]
    property p_irq_off;
        !ctrl_q[dcc_pkg::B_IRQEN] |=> (sts_q & ~$past(sts_q)) == '0;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("event with irq disabled"); // [R10]
    property p_size;
        mem_valid_o |-> mem_size_o == ctrl_q[dcc_pkg::F_WIDTH+:2] &&
            ioff == 32'(idx_q) * ((mem_size_o == dcc_pkg::WID_BYTE) ? 32'h0000_0001 :
            (mem_size_o == dcc_pkg::WID_HALF) ? 32'h0000_0002 : 32'h0000_0004);
    endproperty
    a_size: assert property (p_size) else $error("access width mismatch"); // [R11]
    property p_off;
        state_q == dcc_pkg::ST_IDLE |-> !mem_valid_o;
    endproperty
    a_off: assert property (p_off) else $error("access while off"); // [R12]
    property p_match;
        wr_done && idx_q == irq_item_count_i && ctrl_q[dcc_pkg::B_IRQEN] |=>
            sts_q[dcc_pkg::EV_MATCH];
    endproperty
    a_match: assert property (p_match) else $error("count match lost"); // [R13]
    property p_step;
        wr_done && !last |=> idx_q == $past(idx_q) + 1'b1;
    endproperty
    a_step: assert property (p_step) else $error("index step wrong"); // [R14]
    property p_rearb;
        wr_done |=> !mem_valid_o && state_q != dcc_pkg::ST_RD;
    endproperty
    a_rearb: assert property (p_rearb) else $error("no re-arbitration"); // [R15]
endmodule

// *** dcc_mem_model.sv ***
`timescale 1ns/1ns
module dcc_mem_model (
    input wire logic aclk, // System clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [3:0] delay, // Wait cycles before each ready.
    input wire logic mem_valid, // Access request.
    input wire logic [31:0] mem_addr, // Access byte address.
    output logic mem_ready, // Access completes.
    output logic [31:0] mem_rdata // Load data.
);
    logic [3:0] wait_q;
    logic [31:0] junk_q;
    // Outside ready the data lines keep moving, so a load taken early never matches by luck.
    assign mem_ready = mem_valid && (wait_q == delay);
    assign mem_rdata = mem_ready ? (mem_addr ^ 32'h5a5a_0000) : junk_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || !mem_valid || mem_ready) begin
            wait_q <= 4'h0;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
        junk_q <= aresetn ? (~junk_q ^ {junk_q[30:0], 1'h1}) : 32'h0000_0000;
    end
endmodule

// *** dma_channel_control_tb_top.sv ***
`timescale 1ns/1ns
module dma_channel_control_tb_top;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, dreq_i = 1'h0;
    logic bready = 1'h1, rready = 1'h1;
    logic awready, wready, bvalid, arready, rvalid, bus_request_o, mem_valid_o, mem_write_o;
    logic mem_ready_i, irq_o;
    logic [1:0] bresp, rresp, mem_size_o, rsp;
    logic [2:0] channel_priority_o;
    logic [3:0] wstrb = 4'hf, peer_req_i = 4'h0, delay = 4'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [11:0] peer_prio_i = 12'h000;
    logic [15:0] transfer_length_i = 16'h0000, irq_item_count_i = 16'h0000, item_index_o;
    logic [31:0] wdata = 32'h0000_0000, rdata, mem_addr_o, mem_wdata_o, mem_rdata_i, dat;
    logic [31:0] src_start_i = 32'h1000_0000, dst_start_i = 32'h2000_0100;
    logic [31:0] ld_q[$], st_q[$], sd_q[$];
    int gap_q[$];
    int fails = 0, checked = 0, cycles = 0, gap = 0;

    dcc_channel #(.NUM_CH(4), .CH_ID(1)) dut (.aclk, .aresetn, .awvalid, .awready, .awaddr,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .rvalid, .rready, .rdata, .rresp, .src_start_i, .dst_start_i, .transfer_length_i,
        .irq_item_count_i, .item_index_o, .dreq_i, .peer_req_i, .peer_prio_i, .bus_request_o,
        .channel_priority_o, .mem_valid_o, .mem_write_o, .mem_addr_o, .mem_size_o, .mem_wdata_o,
        .mem_ready_i, .mem_rdata_i, .irq_o);
    dcc_mem_model mem (.aclk, .aresetn, .delay, .mem_valid(mem_valid_o), .mem_addr(mem_addr_o),
        .mem_ready(mem_ready_i), .mem_rdata(mem_rdata_i));

    always #2 aclk = ~aclk;

    // Bus traffic is logged at the falling edge, where the ready path has settled.
    always @(negedge aclk) begin
        cycles++;
        if (mem_valid_o && mem_ready_i) begin
            if (mem_write_o) begin
                st_q.push_back(mem_addr_o);
                sd_q.push_back(mem_wdata_o);
            end else begin
                ld_q.push_back(mem_addr_o);
            end
        end
        if (!mem_valid_o) begin
            gap++;
        end else if (gap != 0) begin
            gap_q.push_back(gap);
            gap = 0;
        end
        if (cycles == 20000) begin
            fails++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (fails == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awvalid <= 1'h1;
        awaddr <= a;
        wvalid <= 1'h1;
        wdata <= d;
        do begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'h0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'h0;
            end
        end while (!bvalid);
        rsp = bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        arvalid <= 1'h1;
        araddr <= a;
        do begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'h0;
            end
        end while (!rvalid);
        dat = rdata;
        rsp = rresp;
    endtask

    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(n, e, dat);
    endtask

    task automatic irqchk(input logic e);
        @(posedge aclk);
        chk("irq_o", {31'h0, e}, {31'h0, irq_o});
    endtask

    task automatic clr_logs();
        ld_q.delete();
        st_q.delete();
        sd_q.delete();
        gap_q.delete();
    endtask

    task automatic run(input logic [15:0] ctl, input logic [15:0] len, input logic [15:0] icnt);
        clr_logs();
        transfer_length_i <= len;
        irq_item_count_i <= icnt;
        wr(dcc_pkg::OFF_CTRL, {16'h0000, ctl});
        do begin
            rd(dcc_pkg::OFF_CTRL);
        end while (dat[0] === 1'h1);
    endtask

    task automatic s_regs();
        chk("bus_request_o", 32'h0, {31'h0, bus_request_o});
        rchk("ctrl", dcc_pkg::OFF_CTRL, 32'h0000_0000);
        rchk("status", dcc_pkg::OFF_STAT, 32'h0000_0000);
        rchk("unmapped", 8'h20, 32'h0000_0000);
        chk("rresp", {30'h0, dcc_pkg::RESP_SLVERR}, {30'h0, rsp});
        wr(dcc_pkg::OFF_INDEX, 32'h0000_0005);
        chk("bresp", {30'h0, dcc_pkg::RESP_SLVERR}, {30'h0, rsp});
        wr(dcc_pkg::OFF_IEN, 32'h0000_0003);
        rchk("ien", dcc_pkg::OFF_IEN, 32'h0000_0003);
    endtask

    task automatic s_widths();
        for (int w = 0; w < 4; w++) begin
            delay <= 4'(w);
            run(16'h0069 | 16'(w << 1), 16'h0002, 16'h0001);
            chk("stores", 32'h3, 32'(st_q.size()));
            for (int i = 0; i < st_q.size(); i++) begin
                chk("src", src_start_i + 32'(i << (w > 2 ? 2 : w)), ld_q[i]);
                chk("dst", dst_start_i + 32'(i << (w > 2 ? 2 : w)), st_q[i]);
                chk("data", (src_start_i + 32'(i << (w > 2 ? 2 : w))) ^ 32'h5a5a_0000, sd_q[i]);
            end
            chk("size", 32'(w), {30'h0, mem_size_o});
            chk("gap", 32'h1, 32'(gap_q[1]));
            chk("ctrl", 32'h0068 | 32'(w << 1), dat);
            chk("index", 32'h0, {16'h0, item_index_o});
            rchk("status", dcc_pkg::OFF_STAT, 32'h3);
            irqchk(1'h1);
            wr(dcc_pkg::OFF_IEN, 32'h0);
            irqchk(1'h0);
            wr(dcc_pkg::OFF_CLR, 32'h3);
            wr(dcc_pkg::OFF_IEN, 32'h3);
            irqchk(1'h0);
        end
    endtask

    task automatic s_fixed_yield();
        delay <= 4'h0;
        run(16'h0805, 16'h0001, 16'h0000);
        chk("stores", 32'h2, 32'(st_q.size()));
        for (int i = 0; i < st_q.size(); i++) begin
            chk("src", src_start_i, ld_q[i]);
            chk("dst", dst_start_i, st_q[i]);
        end
        chk("gap", 32'h2, 32'(gap_q[1]));
        rchk("status", dcc_pkg::OFF_STAT, 32'h0);
        irqchk(1'h0);
    endtask

    task automatic s_arb();
        clr_logs();
        transfer_length_i <= 16'h0000;
        peer_req_i <= 4'h8;
        peer_prio_i <= 12'hc00;
        wr(dcc_pkg::OFF_CTRL, 32'h0000_0505);
        repeat (8) @(posedge aclk);
        chk("loads", 32'h0, 32'(ld_q.size()));
        chk("bus_request_o", 32'h1, {31'h0, bus_request_o});
        chk("prio", 32'h5, {29'h0, channel_priority_o});
        peer_req_i <= 4'h1;
        peer_prio_i <= 12'h005;
        repeat (8) @(posedge aclk);
        chk("loads", 32'h0, 32'(ld_q.size()));
        peer_req_i <= 4'hb;
        peer_prio_i <= 12'ha04;
        repeat (8) @(posedge aclk);
        chk("loads", 32'h1, 32'(ld_q.size()));
        peer_req_i <= 4'h0;
    endtask

    task automatic s_req_circ();
        clr_logs();
        transfer_length_i <= 16'h0001;
        irq_item_count_i <= 16'h0005;
        wr(dcc_pkg::OFF_CTRL, 32'h0000_08fd);
        repeat (8) @(posedge aclk);
        chk("loads", 32'h0, 32'(ld_q.size()));
        dreq_i <= 1'h1;
        while (st_q.size() < 4) @(posedge aclk);
        dreq_i <= 1'h0;
        for (int i = 0; i < 4; i++) begin
            chk("dst", dst_start_i + 32'((i % 2) * 4), st_q[i]);
        end
        chk("gap", 32'h1, 32'(gap_q[1]));
        rchk("ctrl", dcc_pkg::OFF_CTRL, 32'h0000_08fd);
        rchk("status", dcc_pkg::OFF_STAT, 32'h2);
        wr(dcc_pkg::OFF_CTRL, 32'h0);
    endtask

    // A request held high must start only one item per rising edge.
    task automatic s_edge();
        clr_logs();
        transfer_length_i <= 16'h0001;
        wr(dcc_pkg::OFF_CTRL, 32'h0000_2095);
        repeat (4) @(posedge aclk);
        for (int n = 1; n < 3; n++) begin
            dreq_i <= 1'h1;
            repeat (20) @(posedge aclk);
            chk("loads", 32'(n), 32'(ld_q.size()));
            dreq_i <= 1'h0;
            @(posedge aclk);
        end
        chk("index", 32'h0, {16'h0, item_index_o});
        rchk("ctrl", dcc_pkg::OFF_CTRL, 32'h0000_2095);
        wr(dcc_pkg::OFF_CTRL, 32'h0);
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        s_regs();
        s_widths();
        s_fixed_yield();
        s_arb();
        s_req_circ();
        s_edge();
        end_sim();
    end
endmodule
